// ### hdl/wcs_defines.vh
`ifndef WCS_DEFINES_VH
`define WCS_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WCS_IDX_W            8
`define WCS_IDX_BASE_HI      8'h60
`define WCS_IDX_BASE_LO      8'h61
`define WCS_IDX_SLOW_CLK     8'hf0
`define WCS_IDX_ROUTE_SEL    8'hf1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WCS_RST_BASE_HI      8'h00
`define WCS_RST_BASE_LO      8'h00
`define WCS_RST_SLOW_CLK     8'h00
`define WCS_RST_ROUTE_SEL    8'h00

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define WCS_CLK_ABSENT_BIT   0
`define WCS_KEY_OFF_BIT      1
`define WCS_ROUTE_MSB        1
`define WCS_ROUTE_LSB        0
`define WCS_BASE_HI_MASK     8'h0f
`define WCS_BASE_LO_MASK     8'hf8
`define WCS_BASE_HI_MSB      3
`define WCS_BASE_LO_LSB      3
`define WCS_SLOW_CLK_MASK    8'h03
`define WCS_ROUTE_MASK       8'h03

// ----------------------------------------------------------------
// Route select codes
// ----------------------------------------------------------------
`define WCS_ROUTE_MODE_REG   2'h0
`define WCS_ROUTE_PIN_DRV1   2'h1
`define WCS_ROUTE_PIN_BOTH   2'h2
`define WCS_ROUTE_RSVD       2'h3

// ----------------------------------------------------------------
// Host I/O decode
// ----------------------------------------------------------------
`define WCS_IO_ADDR_W        16
`define WCS_IO_BLK_LSB       3
`define WCS_IO_BLK_MSB       11
`define WCS_IO_UPPER_LSB     12

`endif

// ### hdl/wcs_sync.v
`timescale 1ns/1ps
`default_nettype none

module wcs_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk_i,
    input  wire         rst_i,
    // Data
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);

    // ------------------------------------------------------------
    // Two-stage synchroniser, first stage read by the second only
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta_r;
            reg sync_r;

            always @(posedge clk_i) begin
                if (rst_i) begin
                    meta_r <= 1'h0;
                    sync_r <= 1'h0;
                end else begin
                    meta_r <= async_i[g];
                    sync_r <= meta_r;
                end
            end

            assign sync_o[g] = sync_r;
        end
    endgenerate

endmodule

`default_nettype wire

// ### hdl/wcs_io_decode.v
`timescale 1ns/1ps
`default_nettype none
`include "wcs_defines.vh"

module wcs_io_decode (
    // Clock and reset
    input  wire                      clk_i,
    input  wire                      rst_i,
    // Host I/O cycle
    input  wire [`WCS_IO_ADDR_W-1:0] io_addr_i,
    input  wire                      io_valid_i,
    // Programmed base
    input  wire [7:0]                base_hi_i,
    input  wire [7:0]                base_lo_i,
    // Claim
    output reg                       io_hit_o
);

    // ------------------------------------------------------------
    // Eight-byte window compare
    // ------------------------------------------------------------
    wire upper_zero;
    wire block_match;

    assign upper_zero  = ~|io_addr_i[`WCS_IO_ADDR_W-1:`WCS_IO_UPPER_LSB];
    assign block_match = io_addr_i[`WCS_IO_BLK_MSB:`WCS_IO_BLK_LSB] ==
                         {base_hi_i[`WCS_BASE_HI_MSB:0], base_lo_i[7:`WCS_BASE_LO_LSB]};

    always @(posedge clk_i) begin
        if (rst_i) begin
            io_hit_o <= 1'h0;
        end else begin
            io_hit_o <= io_valid_i & upper_zero & block_match;
        end
    end

endmodule

`default_nettype wire

// ### hdl/wcs_top.v
// Functional notes
// - Bit 0 set means slow clock absent
// - Key-wake off blocks slow clock to logic
// - Key-wake bit zero keeps logic running
// - Select 00 lets mode register route floppy
// - Select 01: pin low, drive 1 on port
// - Select 10: pin low, both drives on port
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wcs_defines.vh"

module wcs_top #(
    parameter ADR_W = 10
) (
    // Clock and reset
    input  wire                      clk_i,
    input  wire                      rst_i,
    input  wire                      soft_rst_i,
    // Wishbone slave
    input  wire                      cyc_i,
    input  wire                      stb_i,
    input  wire                      we_i,
    input  wire [ADR_W-1:0]          adr_i,
    input  wire [3:0]                sel_i,
    input  wire [31:0]               dat_i,
    output reg  [31:0]               dat_o,
    output reg                       ack_o,
    // Slow clock and key wake
    input  wire                      slow_clock_input_pin_i,
    output reg                       key_wake_clk_o,
    output reg                       key_wake_run_o,
    output reg                       slow_clock_absent_o,
    // Floppy routing
    input  wire                      route_pin_n_i,
    input  wire                      pp_mode_drv0_i,
    input  wire                      pp_mode_drv1_i,
    output reg                       pp_pins_to_fdc_o,
    output reg                       drv0_on_pp_o,
    output reg                       drv1_on_pp_o,
    // Host I/O decode
    input  wire [`WCS_IO_ADDR_W-1:0] io_addr_i,
    input  wire                      io_valid_i,
    output wire                      smbus_sel_o,
    output reg  [`WCS_IO_ADDR_W-1:0] smbus_base_o
);

    // ------------------------------------------------------------
    // Decode helper
    // ------------------------------------------------------------
    function idx_hit;
        input [ADR_W-1:0]         adr;
        input [`WCS_IDX_W-1:0]    idx;
        begin
            idx_hit = (adr[ADR_W-1:2] == idx[ADR_W-3:0]);
        end
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    reg  [7:0]  base_hi_r;
    reg  [7:0]  base_lo_r;
    reg  [7:0]  slow_clk_r;
    reg  [7:0]  route_sel_r;
    reg         ack_nxt;
    reg  [31:0] dat_nxt;

    wire        req;
    wire        wr_lane0;
    wire        hit_base_hi;
    wire        hit_base_lo;
    wire        hit_slow_clk;
    wire        hit_route;

    assign req          = cyc_i & stb_i & ~ack_o;
    assign wr_lane0     = req & we_i & sel_i[0];
    assign hit_base_hi  = idx_hit(adr_i, `WCS_IDX_BASE_HI);
    assign hit_base_lo  = idx_hit(adr_i, `WCS_IDX_BASE_LO);
    assign hit_slow_clk = idx_hit(adr_i, `WCS_IDX_SLOW_CLK);
    assign hit_route    = idx_hit(adr_i, `WCS_IDX_ROUTE_SEL);

    // ------------------------------------------------------------
    // Write strobes, byte lane 0 only
    // ------------------------------------------------------------
    wire        wr_base_hi;
    wire        wr_base_lo;
    wire        wr_slow_clk;
    wire        wr_route;

    assign wr_base_hi  = wr_lane0 & hit_base_hi;
    assign wr_base_lo  = wr_lane0 & hit_base_lo;
    assign wr_slow_clk = wr_lane0 & hit_slow_clk;
    assign wr_route    = wr_lane0 & hit_route;

    // ------------------------------------------------------------
    // Base address bytes, cleared by every reset kind
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            base_hi_r <= `WCS_RST_BASE_HI;
        end else if (wr_base_hi) begin
            base_hi_r <= dat_i[7:0] & `WCS_BASE_HI_MASK;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            base_lo_r <= `WCS_RST_BASE_LO;
        end else if (wr_base_lo) begin
            // Low three bits read as zero, the window is eight bytes
            base_lo_r <= dat_i[7:0] & `WCS_BASE_LO_MASK;
        end
    end

    // ------------------------------------------------------------
    // Standby-domain config, cleared only by power-on reset
    // ------------------------------------------------------------
    // Soft reset must not drop wake setup while the host sleeps
    always @(posedge clk_i) begin
        if (rst_i) begin
            slow_clk_r <= `WCS_RST_SLOW_CLK;
        end else if (wr_slow_clk) begin
            slow_clk_r <= dat_i[7:0] & `WCS_SLOW_CLK_MASK;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            route_sel_r <= `WCS_RST_ROUTE_SEL;
        end else if (wr_route) begin
            // Reserved bits 7:2 are not stored and read back as zero
            route_sel_r <= dat_i[7:0] & `WCS_ROUTE_MASK;
        end
    end

    // ------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------
    // Unmapped index still acks with zero so the master never hangs
    wire rd_req;

    assign rd_req = req & ~we_i;

    always @* begin
        ack_nxt = req;
        dat_nxt = 32'h0000_0000;
        if (rd_req) begin
            if (hit_base_hi) begin
                dat_nxt[7:0] = base_hi_r;
            end else if (hit_base_lo) begin
                dat_nxt[7:0] = base_lo_r;
            end else if (hit_slow_clk) begin
                dat_nxt[7:0] = slow_clk_r;
            end else if (hit_route) begin
                dat_nxt[7:0] = route_sel_r;
            end else begin
                dat_nxt = 32'h0000_0000;
            end
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'h0;
        end else begin
            ack_o <= ack_nxt;
        end
    end

    // Data bus idles at zero so a stale byte never looks like an answer
    always @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else begin
            dat_o <= dat_nxt;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    wire [1:0] pin_sync;
    wire       slow_clk_s;
    wire       route_pin_n_s;

    wcs_sync #(
        .W (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({route_pin_n_i, slow_clock_input_pin_i}),
        .sync_o  (pin_sync)
    );

    assign slow_clk_s    = pin_sync[0];
    assign route_pin_n_s = pin_sync[1];

    // ------------------------------------------------------------
    // Slow clock and key-wake gating
    // ------------------------------------------------------------
    wire clk_absent;
    wire key_off;
    wire key_gate_en;

    assign clk_absent  = slow_clk_r[`WCS_CLK_ABSENT_BIT];
    assign key_off     = slow_clk_r[`WCS_KEY_OFF_BIT];
    assign key_gate_en = ~key_off & ~clk_absent;

    always @(posedge clk_i) begin
        if (rst_i) begin
            slow_clock_absent_o <= 1'h0;
            key_wake_run_o      <= 1'h0;
            key_wake_clk_o      <= 1'h0;
        end else begin
            slow_clock_absent_o <= clk_absent;
            key_wake_run_o      <= ~key_off;
            // Absent clock pin is grounded, so nothing to pass anyway
            key_wake_clk_o      <= slow_clk_s & key_gate_en;
        end
    end

    // ------------------------------------------------------------
    // Mode-register routing, shared by code 00 and reserved code 11
    // ------------------------------------------------------------
    function [2:0] mode_route;
        input drv0;
        input drv1;
        begin
            mode_route = {drv0 | drv1, drv0, drv1};
        end
    endfunction

    // ------------------------------------------------------------
    // Floppy routing onto printer-port pins
    // ------------------------------------------------------------
    // Route pin syncs to zero in reset, harmless as select is 00 then
    reg  fdc_pins_nxt;
    reg  drv0_nxt;
    reg  drv1_nxt;
    wire route_req;

    assign route_req = ~route_pin_n_s;

    always @* begin
        fdc_pins_nxt = 1'h0;
        drv0_nxt     = 1'h0;
        drv1_nxt     = 1'h0;
        case (route_sel_r[`WCS_ROUTE_MSB:`WCS_ROUTE_LSB])
            `WCS_ROUTE_MODE_REG: begin
                {fdc_pins_nxt, drv0_nxt, drv1_nxt} = mode_route(pp_mode_drv0_i, pp_mode_drv1_i);
            end
            `WCS_ROUTE_PIN_DRV1: begin
                fdc_pins_nxt = route_req;
                drv0_nxt     = 1'h0;
                drv1_nxt     = route_req;
            end
            `WCS_ROUTE_PIN_BOTH: begin
                fdc_pins_nxt = route_req;
                drv0_nxt     = route_req;
                drv1_nxt     = route_req;
            end
            `WCS_ROUTE_RSVD: begin
                // Reserved code behaves as mode-register control
                {fdc_pins_nxt, drv0_nxt, drv1_nxt} = mode_route(pp_mode_drv0_i, pp_mode_drv1_i);
            end
            default: begin
                fdc_pins_nxt = 1'h0;
                drv0_nxt     = 1'h0;
                drv1_nxt     = 1'h0;
            end
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pp_pins_to_fdc_o <= 1'h0;
            drv0_on_pp_o     <= 1'h0;
            drv1_on_pp_o     <= 1'h0;
        end else begin
            pp_pins_to_fdc_o <= fdc_pins_nxt;
            drv0_on_pp_o     <= drv0_nxt;
            drv1_on_pp_o     <= drv1_nxt;
        end
    end

    // ------------------------------------------------------------
    // SMBus I/O window
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i | soft_rst_i) begin
            smbus_base_o <= {`WCS_IO_ADDR_W{1'b0}};
        end else begin
            smbus_base_o <= {base_hi_r, base_lo_r};
        end
    end

    wcs_io_decode u_io_decode (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .io_addr_i  (io_addr_i),
        .io_valid_i (io_valid_i),
        .base_hi_i  (base_hi_r),
        .base_lo_i  (base_lo_r),
        .io_hit_o   (smbus_sel_o)
    );

endmodule

`default_nettype wire

// ### dv/wcs_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "wcs_defines.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module wcs_top_sva #(
    parameter ADR_W = 10
) (
    // Clock and reset
    input wire logic                      clk_i,
    input wire logic                      rst_i,
    input wire logic                      soft_rst_i,
    // Bus
    input wire logic                      cyc_i,
    input wire logic                      stb_i,
    input wire logic                      we_i,
    input wire logic [ADR_W-1:0]          adr_i,
    input wire logic [3:0]                sel_i,
    input wire logic [31:0]               dat_i,
    input wire logic [31:0]               dat_o,
    input wire logic                      ack_o,
    // Slow clock and routing
    input wire logic                      slow_clock_input_pin_i,
    input wire logic                      key_wake_clk_o,
    input wire logic                      key_wake_run_o,
    input wire logic                      slow_clock_absent_o,
    input wire logic                      route_pin_n_i,
    input wire logic                      pp_mode_drv0_i,
    input wire logic                      pp_mode_drv1_i,
    input wire logic                      pp_pins_to_fdc_o,
    input wire logic                      drv0_on_pp_o,
    input wire logic                      drv1_on_pp_o,
    // Host decode
    input wire logic [`WCS_IO_ADDR_W-1:0] io_addr_i,
    input wire logic                      io_valid_i,
    input wire logic                      smbus_sel_o,
    input wire logic [`WCS_IO_ADDR_W-1:0] smbus_base_o
);
    wire        wr  = cyc_i & stb_i & ~ack_o & we_i & sel_i[0];
    wire  [7:0] idx = adr_i[9:2];
    logic [7:0] hi_r, lo_r, cfg_r, rt_r, cfg_d, rt_d;
    logic [2:0] pin_r, sck_r;
    logic [1:0] age_r;
    wire        ok  = (age_r == 2'd3);
    wire        hit = io_valid_i && io_addr_i[15:12] == 4'h0 && io_addr_i[11:3] == {hi_r[3:0], lo_r[7:3]};
    // ----------------------------------------
    // Shadow state, same depth as the output pipe
    // ----------------------------------------
    always @(posedge clk_i) begin
        pin_r <= {pin_r[1:0], route_pin_n_i};
        sck_r <= {sck_r[1:0], slow_clock_input_pin_i};
        cfg_d <= cfg_r;
        rt_d  <= rt_r;
        if (rst_i | soft_rst_i) begin
            hi_r <= 8'h00;
            lo_r <= 8'h00;
        end else if (wr && idx == `WCS_IDX_BASE_HI) begin
            hi_r <= dat_i[7:0] & `WCS_BASE_HI_MASK;
        end else if (wr && idx == `WCS_IDX_BASE_LO) begin
            lo_r <= dat_i[7:0] & `WCS_BASE_LO_MASK;
        end
        if (rst_i) begin
            cfg_r <= 8'h00;
            rt_r  <= 8'h00;
            age_r <= 2'd0;
        end else begin
            if (wr && idx == `WCS_IDX_SLOW_CLK) cfg_r <= dat_i[7:0];
            if (wr && idx == `WCS_IDX_ROUTE_SEL) rt_r <= dat_i[7:0];
            // Synchronisers hold stale pin values until three edges pass
            if (!ok) age_r <= age_r + 2'd1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        ok && cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_ack;
        ack_o ##1 !ack_o;
    endsequence
    a_ack_timing: assert property (s_req |=> s_ack) else $error("ack not a one-cycle answer");
    a_read_idle: assert property (ok && !ack_o |-> dat_o == 32'h0) else $error("read data outside ack");
    a_clk_absent: assert property (ok |-> slow_clock_absent_o == cfg_d[0]) else $error("absent flag wrong");
    a_key_gate: assert property (ok |-> key_wake_clk_o == (sck_r[2] & ~cfg_d[1] & ~cfg_d[0]))
        else $error("key clock gate wrong");
    a_key_run: assert property (ok |-> key_wake_run_o == ~cfg_d[1]) else $error("key run wrong");
    a_route_mode: assert property (ok && rt_d[0] == rt_d[1] |->
        {drv0_on_pp_o, drv1_on_pp_o} == $past({pp_mode_drv0_i, pp_mode_drv1_i})) else $error("mode route wrong");
    a_route_drv1: assert property (ok && rt_d[1:0] == 2'b01 |->
        {pp_pins_to_fdc_o, drv0_on_pp_o, drv1_on_pp_o} == {~pin_r[2], 1'b0, ~pin_r[2]}) else $error("drv1 route wrong");
    a_route_both: assert property (ok && rt_d[1:0] == 2'b10 |->
        {pp_pins_to_fdc_o, drv0_on_pp_o, drv1_on_pp_o} == {3{~pin_r[2]}}) else $error("both route wrong");
    a_base_zero: assert property (smbus_base_o[15:12] == 4'h0 && smbus_base_o[2:0] == 3'h0)
        else $error("base zero bits set");
    a_io_claim: assert property (ok |=> smbus_sel_o == $past(hit)) else $error("claim wrong");
endmodule
bind wcs_top wcs_top_sva #(.ADR_W(ADR_W)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .slow_clock_input_pin_i(slow_clock_input_pin_i), .key_wake_clk_o(key_wake_clk_o),
    .key_wake_run_o(key_wake_run_o), .slow_clock_absent_o(slow_clock_absent_o), .route_pin_n_i(route_pin_n_i),
    .pp_mode_drv0_i(pp_mode_drv0_i), .pp_mode_drv1_i(pp_mode_drv1_i), .pp_pins_to_fdc_o(pp_pins_to_fdc_o),
    .drv0_on_pp_o(drv0_on_pp_o), .drv1_on_pp_o(drv1_on_pp_o), .io_addr_i(io_addr_i), .io_valid_i(io_valid_i),
    .smbus_sel_o(smbus_sel_o), .smbus_base_o(smbus_base_o));
`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk_i = 0, rst_i = 1, soft_rst_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [9:0]  adr_i = 0;
    logic [3:0]  sel_i = 0;
    logic [31:0] dat_i = 0, q;
    logic        sc_i = 0, rp_n_i = 1, m0_i = 0, m1_i = 0, io_valid_i = 0;
    logic [15:0] io_addr_i = 0;
    wire  [31:0] dat_o;
    wire  [15:0] base_o;
    wire         ack_o, kclk_o, krun_o, abs_o, pins_o, d0_o, d1_o, sel_o;
    int          fails = 0, checks_done = 0, cycles = 0;
    always #10 clk_i = ~clk_i;
    wcs_top u_wcs_top (.clk_i(clk_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .slow_clock_input_pin_i(sc_i), .key_wake_clk_o(kclk_o), .key_wake_run_o(krun_o),
        .slow_clock_absent_o(abs_o), .route_pin_n_i(rp_n_i), .pp_mode_drv0_i(m0_i), .pp_mode_drv1_i(m1_i),
        .pp_pins_to_fdc_o(pins_o), .drv0_on_pp_o(d0_o), .drv1_on_pp_o(d1_o), .io_addr_i(io_addr_i),
        .io_valid_i(io_valid_i), .smbus_sel_o(sel_o), .smbus_base_o(base_o));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task give_verdict;
        if (fails == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Cuts a hung handshake short
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            give_verdict;
        end
    end
    task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    task cyc_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task wb(input logic [9:0] a, input logic w, input logic [3:0] s, input logic [7:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= s;
        dat_i <= {24'h0, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
        we_i  <= 0;
    endtask
    task rd(input logic [9:0] a, input logic [7:0] e);
        wb(a, 0, 4'h1, 8'h00);
        chk("read data", q, {24'h0, e});
    endtask
    task io(input logic [15:0] a, input logic e);
        @(posedge clk_i);
        io_addr_i  <= a;
        io_valid_i <= 1;
        @(posedge clk_i);
        io_valid_i <= 0;
        #1;
        chk("claim", sel_o, e);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_regs;
        static logic [9:0] a[4] = '{10'h180, 10'h184, 10'h3c0, 10'h3c4};
        static logic [7:0] m[4] = '{8'h0f, 8'hf8, 8'h03, 8'h03};
        for (int i = 0; i < 4; i++) begin
            rd(a[i], 8'h00);
            wb(a[i], 1, 4'h1, 8'hff);
            wb(a[i], 1, 4'h0, 8'h00);
            rd(a[i], m[i]);
            wb(a[i], 1, 4'h1, 8'h00);
        end
        wb(10'h3fc, 1, 4'h1, 8'hff);
        rd(10'h3fc, 8'h00);
    endtask
    task t_key;
        for (int c = 0; c < 4; c++)
            for (int v = 0; v < 2; v++) begin
                wb(10'h3c0, 1, 4'h1, c[7:0]);
                sc_i <= v[0];
                cyc_n(4);
                #1;
                chk("key", {abs_o, krun_o, kclk_o}, {c[0], ~c[1], v[0] & ~c[1] & ~c[0]});
            end
    endtask
    task t_route;
        logic [2:0] e;
        for (int c = 0; c < 4; c++) begin
            wb(10'h3c4, 1, 4'h1, c[7:0]);
            for (int k = 0; k < 8; k++) begin
                @(posedge clk_i);
                rp_n_i <= k[2];
                m0_i   <= k[0];
                m1_i   <= k[1];
                cyc_n(4);
                #1;
                e = c == 1 ? (k[2] ? 3'b000 : 3'b101) : c == 2 ? {3{~k[2]}} : {k[0] | k[1], k[0], k[1]};
                chk("route", {pins_o, d0_o, d1_o}, e);
            end
        end
    endtask
    task t_io;
        static logic [15:0] b[2] = '{16'h0100, 16'h0ff8};
        for (int i = 0; i < 2; i++) begin
            wb(10'h180, 1, 4'h1, b[i][15:8]);
            wb(10'h184, 1, 4'h1, b[i][7:0]);
            io(b[i], 1);
            io(b[i] + 16'h7, 1);
            io(b[i] + 16'h8, 0);
            io(b[i] - 16'h1, 0);
            io(b[i] | 16'h1000, 0);
            chk("base", base_o, b[i]);
        end
    endtask
    // Soft reset spares the configuration bytes
    task t_soft;
        @(posedge clk_i);
        soft_rst_i <= 1;
        @(posedge clk_i);
        soft_rst_i <= 0;
        #1;
        chk("base after soft reset", base_o, 32'h0);
        rd(10'h180, 8'h00);
        rd(10'h184, 8'h00);
        rd(10'h3c4, 8'h03);
        rd(10'h3c0, 8'h03);
    endtask
    initial begin
        cyc_n(2);
        rst_i <= 0;
        #1;
        chk("reset outputs", {ack_o, kclk_o, krun_o, abs_o, pins_o, d0_o, d1_o, sel_o}, 32'h0);
        chk("reset data", dat_o, 32'h0);
        chk("reset base", base_o, 32'h0);
        t_regs;
        t_key;
        t_route;
        t_io;
        t_soft;
        give_verdict;
    end
endmodule
`default_nettype wire
